// ---- hdl/sorir_top.sv ----
// sync request filter, over-range control and status register bank
`timescale 1ns/1ps
`default_nettype none
module sorir_top
    import sorir_pkg::*;
(
    input  wire logic                          clk_sys_in,
    input  wire logic                          reset_in,
    input  wire logic                          reg_write_in,
    input  wire logic                          reg_read_in,
    input  wire logic [ADDR_W-1:0]             reg_addr_in,
    input  wire logic [DATA_W-1:0]             reg_wdata_in,
    output logic      [DATA_W-1:0]             reg_rdata_out,
    input  wire logic                          link_clk_strobe_in,
    input  wire logic                          sync_request_n_in,
    input  wire logic                          serial_link_enable_in,
    output logic                               resync_request_out,
    input  wire logic                          sample_valid_in,
    input  wire logic [NUM_CH*SAMPLE_W-1:0]    samples_in,
    output logic                               overrange_out_a,
    output logic                               overrange_out_b,
    output logic                               overrange_out_c,
    output logic                               overrange_out_d,
    output logic      [7:0]                    power_profile_code_out,
    output logic                               power_profile_low_out
);
    logic [SYNC_LIMIT_W-1:0] sync_low_count_limit_ff, nxt_sync_low_count_limit;
    logic [7:0]              overrange_level_field_ff, nxt_overrange_level_field;
    logic                    overrange_pin_enable_ff, nxt_overrange_pin_enable;
    logic [OVERRANGE_STRETCH_EXPONENT_W-1:0]      overrange_stretch_exponent_ff, nxt_overrange_stretch_exponent;
    logic [7:0]              power_profile_code_ff, nxt_power_profile_code;
    logic [7:0]              rdata_ff, nxt_rdata;
    logic [INIT_CNT_W-1:0]   init_cnt_ff, nxt_init_cnt;
    logic                    init_done_ff, nxt_init_done;
    logic [5:0]              low_cnt_ff, nxt_low_cnt;
    logic                    resync_ff, nxt_resync;
    logic                    low_prof_ff, nxt_low_prof;
    logic [NUM_CH-1:0]       over;

    // ---------------------------------------------------------------
    // register bank
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_sync_low_count_limit       = sync_low_count_limit_ff;
        nxt_overrange_level_field      = overrange_level_field_ff;
        nxt_overrange_pin_enable       = overrange_pin_enable_ff;
        nxt_overrange_stretch_exponent = overrange_stretch_exponent_ff;
        nxt_power_profile_code         = power_profile_code_ff;
        nxt_rdata                      = rdata_ff;
        if (reg_write_in)
        begin
            unique case (reg_addr_in)
                ADDR_SYNC_THRESHOLD: nxt_sync_low_count_limit = reg_wdata_in[SYNC_LIMIT_W-1:0];
                ADDR_OVR_LEVEL:      nxt_overrange_level_field = reg_wdata_in;
                ADDR_OVR_CONFIG:
                begin
                    nxt_overrange_pin_enable       = reg_wdata_in[OVERRANGE_PIN_ENABLE_BIT];
                    nxt_overrange_stretch_exponent = reg_wdata_in[OVERRANGE_STRETCH_EXPONENT_W-1:0];
                end
                ADDR_POWER_PROFILE2: nxt_power_profile_code = reg_wdata_in;
                default: ;
            endcase
        end
        if (reg_read_in)
        begin
            unique case (reg_addr_in)
                ADDR_SYNC_THRESHOLD:   nxt_rdata = {3'h0, sync_low_count_limit_ff};
                ADDR_OVR_LEVEL:        nxt_rdata = overrange_level_field_ff;
                ADDR_OVR_CONFIG:       nxt_rdata = {4'h0, overrange_pin_enable_ff,
                                                    overrange_stretch_exponent_ff};
                ADDR_STARTUP_PROGRESS: nxt_rdata = {7'h00, init_done_ff};
                ADDR_POWER_PROFILE2:   nxt_rdata = power_profile_code_ff;
                default:               nxt_rdata = 8'h00;
            endcase
        end
        nxt_low_prof = (nxt_power_profile_code == PWR_CODE_LOW);
    end

    // ---------------------------------------------------------------
    // startup sequencer
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_init_cnt  = init_cnt_ff;
        nxt_init_done = init_done_ff;
        if (!init_done_ff)
        begin
            if (init_cnt_ff == INIT_CNT_W'(INIT_CYCLES - 1))
            begin
                nxt_init_done = 1'b1;
            end
            else
            begin
                nxt_init_cnt = init_cnt_ff + 8'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // sync request filter
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_low_cnt = low_cnt_ff;
        nxt_resync  = resync_ff;
        if (!serial_link_enable_in)
        begin
            nxt_low_cnt = 6'h00;
            nxt_resync  = 1'b0;
        end
        else if (link_clk_strobe_in)
        begin
            if (sync_request_n_in)
            begin
                nxt_low_cnt = 6'h00;
                nxt_resync  = 1'b0;
            end
            else
            begin
                if (low_cnt_ff != 6'h3f)
                begin
                    nxt_low_cnt = low_cnt_ff + 6'h01;
                end
                nxt_resync = ({1'b0, low_cnt_ff} + 7'h01 >=
                              {2'h0, sync_low_count_limit_ff} + 7'h01);
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sync_low_count_limit_ff       <= RST_SYNC_THRESHOLD[SYNC_LIMIT_W-1:0];
            overrange_level_field_ff      <= RST_OVR_LEVEL;
            overrange_pin_enable_ff       <= RST_OVR_CONFIG[OVERRANGE_PIN_ENABLE_BIT];
            overrange_stretch_exponent_ff <= RST_OVR_CONFIG[OVERRANGE_STRETCH_EXPONENT_W-1:0];
            power_profile_code_ff         <= RST_POWER_PROFILE2;
            rdata_ff                      <= 8'h00;
            init_cnt_ff                   <= 8'h00;
            init_done_ff                  <= 1'b0;
            low_cnt_ff                    <= 6'h00;
            resync_ff                     <= 1'b0;
            low_prof_ff                   <= 1'b0;
        end
        else
        begin
            sync_low_count_limit_ff       <= nxt_sync_low_count_limit;
            overrange_level_field_ff      <= nxt_overrange_level_field;
            overrange_pin_enable_ff       <= nxt_overrange_pin_enable;
            overrange_stretch_exponent_ff <= nxt_overrange_stretch_exponent;
            power_profile_code_ff         <= nxt_power_profile_code;
            rdata_ff                      <= nxt_rdata;
            init_cnt_ff                   <= nxt_init_cnt;
            init_done_ff                  <= nxt_init_done;
            low_cnt_ff                    <= nxt_low_cnt;
            resync_ff                     <= nxt_resync;
            low_prof_ff                   <= nxt_low_prof;
        end
    end

    // ---------------------------------------------------------------
    // over-range channels
    // ---------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_ch
            sorir_stretch u_str (
                .clk_sys_in      (clk_sys_in),
                .reset_in        (reset_in),
                .sample_valid_in (sample_valid_in),
                .sample_in       (samples_in[ch*SAMPLE_W +: SAMPLE_W]),
                .level_in        (overrange_level_field_ff),
                .exponent_in     (overrange_stretch_exponent_ff),
                .enable_in       (overrange_pin_enable_ff),
                .over_out        (over[ch])
            );
        end
    endgenerate

    assign reg_rdata_out          = rdata_ff;
    assign resync_request_out     = resync_ff;
    assign overrange_out_a        = over[0];
    assign overrange_out_b        = over[1];
    assign overrange_out_c        = over[2];
    assign overrange_out_d        = over[3];
    assign power_profile_code_out = power_profile_code_ff;
    assign power_profile_low_out  = low_prof_ff;
endmodule
`default_nettype wire

// ---- hdl/sorir_pkg.sv ----
// package: register map, field layout, reset values and timing counts
package sorir_pkg;
    localparam int unsigned ADDR_W                = 12;
    localparam int unsigned DATA_W                = 8;
    localparam logic [11:0] ADDR_SYNC_THRESHOLD   = 12'h0210;
    localparam logic [11:0] ADDR_OVR_LEVEL        = 12'h0211;
    localparam logic [11:0] ADDR_OVR_CONFIG       = 12'h0213;
    localparam logic [11:0] ADDR_STARTUP_PROGRESS = 12'h0270;
    localparam logic [11:0] ADDR_POWER_PROFILE2   = 12'h029a;
    localparam logic [7:0]  RST_SYNC_THRESHOLD    = 8'h03;
    localparam logic [7:0]  RST_OVR_LEVEL         = 8'hf2;
    localparam logic [7:0]  RST_OVR_CONFIG        = 8'h07;
    localparam logic [7:0]  RST_POWER_PROFILE2    = 8'h0f;
    localparam int unsigned SYNC_LIMIT_W          = 5;
    localparam int unsigned OVERRANGE_PIN_ENABLE_BIT            = 3;
    localparam int unsigned OVERRANGE_STRETCH_EXPONENT_W               = 3;
    localparam int unsigned NUM_CH                = 4;
    localparam int unsigned SAMPLE_W              = 12;
    localparam int unsigned STRETCH_BASE_LOG2     = 2;
    localparam int unsigned STRETCH_CNT_W         = 10;
    localparam logic [7:0]  PWR_CODE_LOW          = 8'h06;
    localparam logic [7:0]  PWR_CODE_HIGH         = 8'h0f;
    localparam int unsigned INIT_TIME_NS          = 1000;
    localparam int unsigned CLK_PERIOD_NS         = 100;
    localparam int unsigned INIT_CYCLES           = (INIT_TIME_NS + CLK_PERIOD_NS - 1)
                                                    / CLK_PERIOD_NS;
    localparam int unsigned INIT_CNT_W            = 8;
endpackage

// ---- hdl/sorir_stretch.sv ----
// one channel over-range comparator with pulse stretcher
`timescale 1ns/1ps
`default_nettype none
module sorir_stretch
    import sorir_pkg::*;
(
    input  wire logic                 clk_sys_in,
    input  wire logic                 reset_in,
    input  wire logic                 sample_valid_in,
    input  wire logic [SAMPLE_W-1:0]  sample_in,
    input  wire logic [7:0]           level_in,
    input  wire logic [OVERRANGE_STRETCH_EXPONENT_W-1:0]   exponent_in,
    input  wire logic                 enable_in,
    output logic                      over_out
);
    logic [SAMPLE_W-1:0]      mag;
    logic [7:0]               mag8;
    logic                     hit;
    logic [STRETCH_CNT_W-1:0] cnt_ff;
    logic [STRETCH_CNT_W-1:0] nxt_cnt;
    logic                     over_ff;
    logic                     nxt_over;
    logic [STRETCH_CNT_W-1:0] span;

    // ---------------------------------------------------------------
    // compare and stretch
    // ---------------------------------------------------------------
    always_comb
    begin
        mag      = sample_in[SAMPLE_W-1] ? ~sample_in : sample_in;
        mag8     = mag[SAMPLE_W-2:SAMPLE_W-9];
        hit      = sample_valid_in && ({1'b0, mag8} + 9'h001 >= {1'b0, level_in}) &&
                   (level_in != 8'h00 || 1'b1);
        span     = STRETCH_CNT_W'(1) << (STRETCH_BASE_LOG2 + 32'(exponent_in));
        nxt_cnt  = cnt_ff;
        if (hit)
        begin
            nxt_cnt = span - 10'h001;
        end
        else if (sample_valid_in && cnt_ff != 10'h000)
        begin
            nxt_cnt = cnt_ff - 10'h001;
        end
        nxt_over = enable_in && (hit || (over_ff && !(sample_valid_in && cnt_ff == 10'h000)))
                   && !(over_ff == 1'b0 && !hit);
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cnt_ff  <= 10'h000;
            over_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            over_ff <= nxt_over;
        end
    end

    assign over_out = over_ff;
endmodule
`default_nettype wire

// ---- tb/sorir_top_properties.sv ----
// checker: port properties of the sync filter, over-range pins and registers
`timescale 1ns/1ps
`default_nettype none
module sorir_top_properties
    import sorir_pkg::*;
(
    input wire logic              clk_sys_in,
    input wire logic              reset_in,
    input wire logic              reg_write_in,
    input wire logic              reg_read_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic [DATA_W-1:0] reg_rdata_out,
    input wire logic              link_clk_strobe_in,
    input wire logic              sync_request_n_in,
    input wire logic              serial_link_enable_in,
    input wire logic              resync_request_out,
    input wire logic              sample_valid_in,
    input wire logic              overrange_out_a,
    input wire logic              overrange_out_b,
    input wire logic              overrange_out_c,
    input wire logic              overrange_out_d,
    input wire logic [7:0]        power_profile_code_out,
    input wire logic              power_profile_low_out
);
    logic       en_ff;
    logic [3:0] age_ff;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    // shadow of the pin enable and a saturating age since reset
    always_ff @(posedge clk_sys_in or posedge reset_in)
        if (reset_in)
            {en_ff, age_ff} <= 5'h00;
        else
            {en_ff, age_ff} <= {(reg_write_in && reg_addr_in == ADDR_OVR_CONFIG) ?
                reg_wdata_in[OVERRANGE_PIN_ENABLE_BIT] : en_ff, age_ff + {3'h0, age_ff != 4'hf}};
    chk_resync_clear: assert property (link_clk_strobe_in && serial_link_enable_in
        && sync_request_n_in |-> ##[1:2] !resync_request_out) else $error("resync stuck");
    chk_link_off: assert property (!serial_link_enable_in
        |-> ##[1:2] !resync_request_out) else $error("resync while link off");
    chk_resync_run: assert property ($rose(resync_request_out)
        |-> !$past(sync_request_n_in) || !$past(sync_request_n_in, 2)) else $error("bad resync");
    chk_code_write: assert property (reg_write_in && reg_addr_in == ADDR_POWER_PROFILE2
        |=> power_profile_code_out == $past(reg_wdata_in)) else $error("code not written");
    chk_low_flag: assert property (
        power_profile_low_out == (power_profile_code_out == PWR_CODE_LOW)) else $error("low flag");
    chk_read_code: assert property (reg_read_in && !reg_write_in
        && reg_addr_in == ADDR_POWER_PROFILE2 |=> reg_rdata_out == power_profile_code_out)
        else $error("profile readback");
    chk_pins_off: assert property (!en_ff |=> !(overrange_out_a || overrange_out_b
        || overrange_out_c || overrange_out_d)) else $error("pin high while disabled");
    chk_pin_cause: assert property ($rose(overrange_out_b)
        |-> $past(sample_valid_in) && $past(en_ff)) else $error("pin rose without cause");
    chk_init_zero: assert property (reg_read_in && age_ff < 4'h8
        && reg_addr_in == ADDR_STARTUP_PROGRESS |=> reg_rdata_out == 8'h00) else $error("early");
endmodule
bind sorir_top sorir_top_properties u_props (.clk_sys_in, .reset_in, .reg_write_in, .reg_read_in,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .link_clk_strobe_in, .sync_request_n_in,
    .serial_link_enable_in, .resync_request_out, .sample_valid_in, .overrange_out_a,
    .overrange_out_b, .overrange_out_c, .overrange_out_d, .power_profile_code_out,
    .power_profile_low_out);
`default_nettype wire

// ---- tb/sorir_sync_partner.sv ----
// partner: link receiver model driving the sync request line
`timescale 1ns/1ps
`default_nettype none
module sorir_sync_partner
(
    input  wire logic       clk_sys_in,
    input  wire logic       strobe_in,
    input  wire logic       start_in,
    input  wire logic [5:0] run_in,
    output logic            sync_n_out,
    output logic            busy_out
);
    logic [5:0] left_ff = 6'h00;
    // holds the line low for run_in link-clock samples, then releases it high
    always @(posedge clk_sys_in)
        if (start_in)
            left_ff <= run_in;
        else if (strobe_in && left_ff != 6'h00)
            left_ff <= left_ff - 6'h01;
    assign sync_n_out = (left_ff == 6'h00);
    assign busy_out   = (left_ff != 6'h00);
endmodule
`default_nettype wire

// ---- tb/sync_overrange_init_regs_bench.sv ----
// testbench: registers, sync filter and over-range pins of the block
`timescale 1ns/1ps
`default_nettype none
module sync_overrange_init_regs_bench;
    import sorir_pkg::*;
    logic        clk_sys_in = 1'b0, reset_in = 1'b1, link_clk_strobe_in = 1'b0, rd_seen = 1'b0;
    logic        reg_write_in = 1'b0, reg_read_in = 1'b0, serial_link_enable_in = 1'b0;
    logic        sample_valid_in = 1'b1, start = 1'b0, seen = 1'b0, busy, sync_n, resync;
    logic        ov_a, ov_b, ov_c, ov_d, low;
    logic [11:0] reg_addr_in = 12'h0000;
    logic [7:0]  reg_wdata_in = 8'h00, rdata, code, exp_q[$];
    logic [47:0] samples_in = 48'h0000_0000_0000;
    logic [15:0] lf = 16'h002f;
    logic [5:0]  run6 = 6'h00;
    logic [7:0]  wv;
    int          errors = 0, comparisons = 0, n, cnt;
    logic [11:0] ra[6] = '{12'h0210, 12'h0211, 12'h0213, 12'h029a, 12'h0270, 12'h0212};
    logic [7:0]  rv[6] = '{8'h03, 8'hf2, 8'h07, 8'h0f, 8'h01, 8'h00};
    logic [7:0]  rm[4] = '{8'h1f, 8'hff, 8'h0f, 8'hff};
    logic [7:0]  lim[5] = '{8'h02, 8'h02, 8'h00, 8'h1f, 8'h1f};
    logic [5:0]  run[5] = '{6'h02, 6'h03, 6'h01, 6'h1f, 6'h20};
    sorir_top u_dut (.clk_sys_in, .reset_in, .reg_write_in, .reg_read_in, .reg_addr_in,
        .reg_wdata_in, .reg_rdata_out(rdata), .link_clk_strobe_in, .sync_request_n_in(sync_n),
        .serial_link_enable_in, .resync_request_out(resync), .sample_valid_in, .samples_in,
        .overrange_out_a(ov_a), .overrange_out_b(ov_b), .overrange_out_c(ov_c),
        .overrange_out_d(ov_d), .power_profile_code_out(code), .power_profile_low_out(low));
    sorir_sync_partner u_rx (.clk_sys_in, .strobe_in(link_clk_strobe_in), .start_in(start),
        .run_in(run6), .sync_n_out(sync_n), .busy_out(busy));
    always #50 clk_sys_in = ~clk_sys_in;
    always @(negedge clk_sys_in) link_clk_strobe_in <= ~link_clk_strobe_in;
    always @(posedge clk_sys_in) rd_seen <= reg_read_in;
    always @(posedge clk_sys_in) if (resync === 1'b1) seen <= 1'b1;
    always @(negedge clk_sys_in) if (rd_seen) cmp_rd(rdata, exp_q.pop_front());
    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        errors += int'(got !== exp);
        if (got !== exp) $display("ERROR %0t data %h exp %h", $time, got, exp);
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        comparisons++;
        errors += int'(got !== exp);
        if (got !== exp) $display("ERROR %0t flag %b exp %b", $time, got, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        {reg_write_in, reg_addr_in, reg_wdata_in} = {1'b1, a, d};
        @(negedge clk_sys_in);
        reg_write_in = 1'b0;
        @(negedge clk_sys_in);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        {reg_read_in, reg_addr_in} = {1'b1, a};
        exp_q.push_back(e);
        @(negedge clk_sys_in);
        reg_read_in = 1'b0;
        @(negedge clk_sys_in);
    endtask
    task automatic smp(input logic [11:0] hit);
        lf = lfsr_step(lf);
        samples_in = {4'h0, lf[7:0], 4'h0, lf[15:8], hit, 4'h0, lf[11:4]};
        @(negedge clk_sys_in);
    endtask
    task automatic test_done();
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #1_000_000;
        errors++;
        test_done();
    end
    initial
    begin
        repeat (3) @(negedge clk_sys_in);
        reset_in = 1'b0;
        rd(ADDR_STARTUP_PROGRESS, 8'h00);
        repeat (12) @(negedge clk_sys_in);
        for (n = 0; n < 6; n++)
            rd(ra[n], rv[n]);
        for (n = 0; n < 4; n++)
        begin
            lf = lfsr_step(lf);
            wv = (n == 3) ? (lf[0] ? PWR_CODE_LOW : PWR_CODE_HIGH) : lf[7:0] & rm[n];
            wr(ra[n], wv);
            rd(ra[n], wv);
        end
        wr(ADDR_STARTUP_PROGRESS, 8'h00);
        rd(ADDR_STARTUP_PROGRESS, 8'h01);
        for (n = 0; n < 2; n++)
        begin
            wr(ADDR_POWER_PROFILE2, (n != 0) ? PWR_CODE_HIGH : PWR_CODE_LOW);
            cmp_rd(code, (n != 0) ? 8'h0f : 8'h06);
            cmp_bit(low, n == 0);
        end
        for (n = 0; n < 5; n++)
        begin
            serial_link_enable_in = 1'b0;
            wr(ADDR_SYNC_THRESHOLD, lim[n]);
            serial_link_enable_in = 1'b1;
            seen = 1'b0;
            run6 = run[n];
            start = 1'b1;
            @(negedge clk_sys_in);
            start = 1'b0;
            @(negedge clk_sys_in);
            for (cnt = 0; busy && cnt < 200; cnt++)
                @(negedge clk_sys_in);
            cmp_bit(cnt < 200, 1'b1);
            repeat (6) @(negedge clk_sys_in);
            cmp_bit(seen, run[n] > lim[n]);
        end
        wr(ADDR_OVR_LEVEL, 8'h80);
        wr(ADDR_OVR_CONFIG, 8'h00);
        smp(12'h7ff);
        smp(12'h000);
        cmp_bit(ov_a | ov_b | ov_c | ov_d, 1'b0);
        repeat (8) smp(12'h000);
        for (n = 0; n < 2; n++)
        begin
            wr(ADDR_OVR_CONFIG, 8'h08 | n[7:0]);
            smp(12'h3f0);
            cmp_bit(ov_b, 1'b0);
            smp((n != 0) ? 12'h801 : 12'h3f8);
            cmp_bit(ov_b, 1'b1);
            cmp_bit(ov_a | ov_c | ov_d, 1'b0);
            for (cnt = 1; ov_b && cnt < 100; cnt += int'(sample_valid_in))
            begin
                sample_valid_in = lf[0] | lf[3];
                smp(12'h000);
            end
            sample_valid_in = 1'b1;
            cmp_bit(cnt >= (4 << n) && cnt <= (4 << n) + 2, 1'b1);
        end
        repeat (4) @(negedge clk_sys_in);
        test_done();
    end
endmodule
`default_nettype wire
